/* File: design/efm_pkg.sv */
// Constants shared by the exact-frequency modulator control block
package efm_pkg;

	// ---------------------------------------------------------------
	// Register port geometry
	// ---------------------------------------------------------------
	localparam int unsigned EFM_ADDR_W = 5;
	localparam int unsigned EFM_DATA_W = 24;

	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [4:0] EFM_REG_PTR   = 5'h00;
	localparam logic [4:0] EFM_REG_PWR   = 5'h01;
	localparam logic [4:0] EFM_REG_INT   = 5'h03;
	localparam logic [4:0] EFM_REG_FRAC  = 5'h04;
	localparam logic [4:0] EFM_REG_MCFG  = 5'h06;
	localparam logic [4:0] EFM_REG_EXACT = 5'h0c;
	localparam logic [4:0] EFM_REG_SEED  = 5'h1a;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int unsigned EFM_PTR_W        = 5;
	localparam int unsigned EFM_PWR_PIN_SEL  = 0;
	localparam int unsigned EFM_PWR_SW_PD    = 1;
	localparam int unsigned EFM_PWR_KEEP_LSB = 2;
	localparam int unsigned EFM_PWR_KEEP_W   = 6;
	localparam int unsigned EFM_MCFG_BYPASS  = 7;
	localparam int unsigned EFM_MCFG_ENABLE  = 11;

	// ---------------------------------------------------------------
	// Values after reset
	// ---------------------------------------------------------------
	localparam logic [23:0] EFM_RST_PTR   = 24'h000000;
	localparam logic [23:0] EFM_RST_PWR   = 24'h000001;
	localparam logic [23:0] EFM_RST_INT   = 24'h000014;
	localparam logic [23:0] EFM_RST_FRAC  = 24'h000000;
	localparam logic [23:0] EFM_RST_MCFG  = 24'h000080;
	localparam logic [23:0] EFM_RST_EXACT = 24'h000000;
	localparam logic [23:0] EFM_RST_SEED  = 24'h000000;

	// Arbitrary identification value, read back at offset zero
	localparam logic [23:0] EFM_CHIP_ID   = 24'h5a0001;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int unsigned EFM_CLK_PERIOD_NS = 20;
	localparam int unsigned EFM_POR_TIME_NS   = 250000;
	localparam int unsigned EFM_POR_CYCLES    = EFM_POR_TIME_NS / EFM_CLK_PERIOD_NS;
	localparam int unsigned EFM_POR_CNT_W     = 24;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [0:0] {
		EFM_ST_POR_WAIT = 1'b0,
		EFM_ST_RUN      = 1'b1
	} efm_state_t;

endpackage

/* File: design/efm_phase_acc.sv */
// Modulator phase accumulator with seed reload
`timescale 1ns/1ps

module efm_phase_acc (
	// Clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        rst_i,
	// Control
	input  wire logic        load_i,
	input  wire logic [23:0] seed_i,
	input  wire logic        step_i,
	input  wire logic [23:0] frac_i,
	// Results
	output logic      [23:0] phase_o,
	output logic             carry_o
);

	typedef struct packed {
		logic [23:0] phase;
		logic        carry;
	} efm_acc_t;

	efm_acc_t s_q;
	efm_acc_t s_d;
	logic [24:0] sum;

	always_comb begin
		s_d   = s_q;
		sum   = {1'b0, s_q.phase} + {1'b0, frac_i};
		if (load_i) begin
			// Reload wins over a step in the same cycle
			s_d.phase = seed_i;
			s_d.carry = 1'b0;
		end else if (step_i) begin
			// Fixed binary modulus: wrap at two to the 24th
			s_d.phase = sum[23:0];
			s_d.carry = sum[24];
		end else begin
			s_d.carry = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign phase_o = s_q.phase;
	assign carry_o = s_q.carry;

endmodule // efm_phase_acc

/* File: design/efm_ctrl.sv */
// Exact-frequency modulator control: registers, resets, power-down, seeding
//
// Contract
// - Channel stepping rewrites only the fractional word; that write alone retunes.
// - 24-bit seed sets accumulator start phase; needs exact mode active.
// - Seed (zero outside exact mode) reloads into the accumulator whenever a new fractional word arrives.
// - Power-on reset loads all register defaults at once and holds them for about 250 us.
// - A write to offset zero soft resets the synthesizer registers.
// - With pin control selected, low chip enable enters power-down.
// - Register writes and reads keep working during power-down.
// - With pin control off, power-down follows the software bit.
// - Bits two to seven keep one block each powered during power-down.
// - Fractional part is the fractional word over a fixed 2^24 modulus.
`timescale 1ns/1ps

module efm_ctrl
	import efm_pkg::*;
#(
	parameter int unsigned POR_CYCLES = efm_pkg::EFM_POR_CYCLES
) (
	// Clock and reset
	input  wire logic                         ref_clk_i,
	input  wire logic                         rst_i,
	// Register port
	input  wire logic                         reg_wr_i,
	input  wire logic [efm_pkg::EFM_ADDR_W-1:0] reg_addr_i,
	input  wire logic [efm_pkg::EFM_DATA_W-1:0] reg_wdata_i,
	output logic      [efm_pkg::EFM_DATA_W-1:0] reg_rdata_o,
	output logic                              reg_ready_o,
	// Pins and rate enable
	input  wire logic                         chip_enable_pin_i,
	input  wire logic                         detector_tick_i,
	// Power control
	output logic                              power_down_o,
	output logic                              clocks_en_o,
	output logic      [efm_pkg::EFM_PWR_KEEP_W-1:0] block_on_o,
	// Divider and modulator state
	output logic      [23:0]                  int_ratio_o,
	output logic      [23:0]                  frac_word_o,
	output logic      [23:0]                  exact_ratio_o,
	output logic      [23:0]                  div_ratio_o,
	output logic      [23:0]                  phase_o,
	output logic                              mod_active_o,
	output logic                              exact_mode_o,
	output logic                              retune_o
);

	import efm_pkg::*;

	localparam logic [EFM_POR_CNT_W-1:0] POR_LAST = EFM_POR_CNT_W'(POR_CYCLES - 1);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		efm_state_t                  st;
		logic [EFM_POR_CNT_W-1:0]    por_cnt;
		logic [EFM_PTR_W-1:0]        rd_ptr;
		logic [23:0]                 pwr;
		logic [23:0]                 int_ratio;
		logic [23:0]                 frac;
		logic [23:0]                 mcfg;
		logic [23:0]                 exact;
		logic [23:0]                 seed;
		logic [23:0]                 rdata;
		logic                        retune;
		logic                        load;
		logic [23:0]                 div_ratio;
	} efm_regs_t;

	efm_regs_t s_q;
	efm_regs_t s_d;

	logic        pd_now;
	logic        mod_on;
	logic        exact_on;
	logic        wr_ok;
	logic        step;
	logic [23:0] acc_phase;
	logic        acc_carry;

	// ---------------------------------------------------------------
	// Power-down selection
	// ---------------------------------------------------------------
	always_comb begin
		if (s_q.pwr[EFM_PWR_PIN_SEL]) begin
			pd_now = ~chip_enable_pin_i;
		end else begin
			pd_now = s_q.pwr[EFM_PWR_SW_PD];
		end
	end

	// Modulator in circuit only with enable set and bypass clear
	assign mod_on   = s_q.mcfg[EFM_MCFG_ENABLE] & ~s_q.mcfg[EFM_MCFG_BYPASS];
	// Nonzero exact ratio marks exact mode active
	assign exact_on = (s_q.exact != 24'h000000);
	// Writes keep being taken in power-down; only the start-up wait refuses them
	assign wr_ok    = reg_wr_i & (s_q.st == EFM_ST_RUN);
	// Internal clocks stop in power-down, so the accumulator stops stepping
	assign step     = detector_tick_i & mod_on & ~pd_now;

	// ---------------------------------------------------------------
	// Next-state logic
	// ---------------------------------------------------------------
	always_comb begin
		s_d        = s_q;
		s_d.retune = 1'b0;
		s_d.load   = 1'b0;

		unique case (s_q.st)
			EFM_ST_POR_WAIT: begin
				// Registers held at defaults until the start-up time elapses
				if (s_q.por_cnt == POR_LAST) begin
					s_d.st = EFM_ST_RUN;
				end else begin
					s_d.por_cnt = s_q.por_cnt + EFM_POR_CNT_W'(1);
				end
			end
			EFM_ST_RUN: begin
				if (wr_ok) begin
					unique case (reg_addr_i)
						EFM_REG_PTR: begin
							// Soft reset, but the new read pointer is kept
							s_d.pwr       = EFM_RST_PWR;
							s_d.int_ratio = EFM_RST_INT;
							s_d.frac      = EFM_RST_FRAC;
							s_d.mcfg      = EFM_RST_MCFG;
							s_d.exact     = EFM_RST_EXACT;
							s_d.seed      = EFM_RST_SEED;
							s_d.rd_ptr    = reg_wdata_i[EFM_PTR_W-1:0];
						end
						EFM_REG_PWR:   s_d.pwr = reg_wdata_i;
						EFM_REG_INT:   s_d.int_ratio = reg_wdata_i;
						EFM_REG_FRAC: begin
							s_d.frac   = reg_wdata_i;
							s_d.retune = 1'b1;
							s_d.load   = 1'b1;
						end
						EFM_REG_MCFG:  s_d.mcfg = reg_wdata_i;
						EFM_REG_EXACT: s_d.exact = reg_wdata_i;
						EFM_REG_SEED:  s_d.seed = reg_wdata_i;
						default: begin
						end
					endcase
				end
			end
		endcase

		// Read data follows the pointer, refreshed every cycle
		unique case (s_q.rd_ptr)
			EFM_REG_PTR:   s_d.rdata = EFM_CHIP_ID;
			EFM_REG_PWR:   s_d.rdata = s_q.pwr;
			EFM_REG_INT:   s_d.rdata = s_q.int_ratio;
			EFM_REG_FRAC:  s_d.rdata = s_q.frac;
			EFM_REG_MCFG:  s_d.rdata = s_q.mcfg;
			EFM_REG_EXACT: s_d.rdata = s_q.exact;
			EFM_REG_SEED:  s_d.rdata = s_q.seed;
			default:       s_d.rdata = 24'h000000;
		endcase

		// Integer ratio plus modulator carry; fraction is frac over 2^24
		if (mod_on) begin
			s_d.div_ratio = s_q.int_ratio + {23'h000000, acc_carry};
		end else begin
			s_d.div_ratio = s_q.int_ratio;
		end
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			s_q.st        <= EFM_ST_POR_WAIT;
			s_q.por_cnt   <= '0;
			s_q.rd_ptr    <= EFM_RST_PTR[EFM_PTR_W-1:0];
			s_q.pwr       <= EFM_RST_PWR;
			s_q.int_ratio <= EFM_RST_INT;
			s_q.frac      <= EFM_RST_FRAC;
			s_q.mcfg      <= EFM_RST_MCFG;
			s_q.exact     <= EFM_RST_EXACT;
			s_q.seed      <= EFM_RST_SEED;
			s_q.rdata     <= 24'h000000;
			s_q.retune    <= 1'b0;
			s_q.load      <= 1'b0;
			s_q.div_ratio <= EFM_RST_INT;
		end else begin
			s_q <= s_d;
		end
	end

	// ---------------------------------------------------------------
	// Modulator phase accumulator
	// ---------------------------------------------------------------
	// Seed is honoured only in exact mode; otherwise restart from zero
	efm_phase_acc efm_phase_acc_i (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.load_i    (s_q.load),
		.seed_i    (exact_on ? s_q.seed : 24'h000000),
		.step_i    (step),
		.frac_i    (s_q.frac),
		.phase_o   (acc_phase),
		.carry_o   (acc_carry)
	);

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign reg_rdata_o   = s_q.rdata;
	assign reg_ready_o   = (s_q.st == EFM_ST_RUN);
	assign power_down_o  = pd_now;
	assign clocks_en_o   = ~pd_now;
	// Keep-on bits in order: bias, detector, pump, reference, oscillator, pads
	assign block_on_o    = {EFM_PWR_KEEP_W{~pd_now}}
	                     | s_q.pwr[EFM_PWR_KEEP_LSB +: EFM_PWR_KEEP_W];
	assign int_ratio_o   = s_q.int_ratio;
	assign frac_word_o   = s_q.frac;
	assign exact_ratio_o = s_q.exact;
	assign div_ratio_o   = s_q.div_ratio;
	assign phase_o       = acc_phase;
	assign mod_active_o  = mod_on;
	assign exact_mode_o  = exact_on;
	assign retune_o      = s_q.retune;

endmodule // efm_ctrl

/* File: bench/efm_ctrl_monitor.sv */
// Port checker for the modulator control block
`timescale 1ns/1ps

module efm_ctrl_monitor
	import efm_pkg::*;
#(
	parameter int unsigned POR_CYCLES = efm_pkg::EFM_POR_CYCLES
) (
	// Clock, reset and register port
	input wire logic                                ref_clk_i,
	input wire logic                                rst_i,
	input wire logic                                reg_wr_i,
	input wire logic [efm_pkg::EFM_ADDR_W-1:0]     reg_addr_i,
	input wire logic [efm_pkg::EFM_DATA_W-1:0]     reg_wdata_i,
	input wire logic                                reg_ready_o,
	// Power and modulator state
	input wire logic                                power_down_o,
	input wire logic [efm_pkg::EFM_PWR_KEEP_W-1:0] block_on_o,
	input wire logic [23:0]                         int_ratio_o,
	input wire logic [23:0]                         frac_word_o,
	input wire logic [23:0]                         div_ratio_o,
	input wire logic [23:0]                         phase_o,
	input wire logic                                mod_active_o,
	input wire logic                                exact_mode_o,
	input wire logic                                retune_o
);
	// ---------------------------------------------------------------
	// Helpers and properties
	// ---------------------------------------------------------------
	int unsigned cnt_q;
	wire logic   wf = reg_wr_i && reg_ready_o && reg_addr_i == EFM_REG_FRAC;
	wire logic   wi = reg_wr_i && reg_ready_o && reg_addr_i inside {EFM_REG_INT, EFM_REG_PTR};

	// Saturates just past the wait so a long run cannot wrap it
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) cnt_q <= 0;
		else if (cnt_q <= POR_CYCLES) cnt_q <= cnt_q + 1;
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	property p_por_wait; cnt_q < POR_CYCLES |-> !reg_ready_o; endproperty
	a_por_wait: assert property (p_por_wait) else $error("ready too early");
	property p_por_done; cnt_q > POR_CYCLES |-> reg_ready_o; endproperty
	a_por_done: assert property (p_por_done) else $error("ready missing");
	property p_early; reg_wr_i && !reg_ready_o |=> !retune_o; endproperty
	a_early: assert property (p_early) else $error("early write taken");
	property p_frac_wr; wf |=> retune_o && frac_word_o == $past(reg_wdata_i); endproperty
	a_frac_wr: assert property (p_frac_wr) else $error("fraction write lost");
	property p_retune_only; retune_o |-> $past(wf); endproperty
	a_retune_only: assert property (p_retune_only) else $error("stray retune");
	property p_int_hold; !wi |=> $stable(int_ratio_o); endproperty
	a_int_hold: assert property (p_int_hold) else $error("integer ratio moved");
	property p_bypass; !mod_active_o |=> div_ratio_o == $past(int_ratio_o); endproperty
	a_bypass: assert property (p_bypass) else $error("ratio off in bypass");
	property p_load_plain; retune_o && !exact_mode_o |=> phase_o == 24'h000000; endproperty
	a_load_plain: assert property (p_load_plain) else $error("seed without exact");
	property p_pd_freeze; power_down_o && !retune_o |=> $stable(phase_o); endproperty
	a_pd_freeze: assert property (p_pd_freeze) else $error("phase moved");
	property p_keep; !power_down_o |-> block_on_o == 6'h3f; endproperty
	a_keep: assert property (p_keep) else $error("block off while up");

	c_frac: cover property (wf);
	c_pd_wr: cover property (power_down_o && reg_wr_i);
	c_seed: cover property (retune_o && exact_mode_o);
endmodule // efm_ctrl_monitor

bind efm_ctrl efm_ctrl_monitor #(.POR_CYCLES(POR_CYCLES)) efm_ctrl_monitor_i (
	.ref_clk_i, .rst_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i, .reg_ready_o, .power_down_o,
	.block_on_o, .int_ratio_o, .frac_word_o, .div_ratio_o, .phase_o, .mod_active_o,
	.exact_mode_o, .retune_o
);

/* File: bench/efm_host_model.sv */
// Host model that programs the modulator registers
`timescale 1ns/1ps

module efm_host_model (
	// Clock
	input  wire logic                            ref_clk_i,
	// Register writes
	output logic                                 reg_wr_o,
	output logic [efm_pkg::EFM_ADDR_W-1:0]       reg_addr_o,
	output logic [efm_pkg::EFM_DATA_W-1:0]       reg_wdata_o
);
	import efm_pkg::*;
	initial begin
		reg_wr_o = 1'b0;
		reg_addr_o = 5'h00;
		reg_wdata_o = 24'h000000;
	end

	task wr(input logic [4:0] a, input logic [23:0] d);
		@(negedge ref_clk_i);
		reg_wr_o = 1'b1;
		reg_addr_o = a;
		reg_wdata_o = d;
		@(negedge ref_clk_i);
		reg_wr_o = 1'b0;
	endtask

	// 2800.2 MHz at a 61.44 MHz detector rate, 100 kHz channels; gcd far above rate/2^24
	task tune(input logic [23:0] seed);
		wr(EFM_REG_INT, 24'h00002d);
		wr(EFM_REG_EXACT, 24'h000c00);
		wr(EFM_REG_SEED, seed);
		wr(EFM_REG_MCFG, 24'h000800);
		wr(EFM_REG_FRAC, 24'h938000);
	endtask
endmodule // efm_host_model

/* File: bench/efm_ctrl_tb.sv */
// Self-checking bench for the modulator control block
`timescale 1ns/1ps
`define CHK(id, e, g) \
	begin \
		cmp_count++; \
		if ((g) !== (e)) begin \
			n_mismatch++; \
			$display("MISMATCH %s exp %h got %h", nm[id], e, g); \
		end \
	end

module efm_ctrl_tb;
	import efm_pkg::*;
	typedef struct packed {logic [3:0] id; logic [23:0] v;} efm_exp_t;
	logic        ref_clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        chip_enable_pin = 1'b1;
	logic        tick = 1'b0;
	logic        wr, ready, pd, clk_en, mact, emode, retune;
	logic [4:0]  addr;
	logic [5:0]  bon;
	logic [23:0] wdata, rdata, int_r, frac, exact, div, phase, seed, r, got;
	efm_exp_t    q[$];
	efm_exp_t    e;
	int          n_mismatch = 0;
	int          cmp_count = 0;
	int          sd = 86689;
	int          i;
	string       nm[10] = '{"rdata", "power_down", "block_on", "clocks_en", "phase",
		"int_ratio", "frac_word", "exact_ratio", "div_ratio", "mode_flags"};
	logic [4:0]  ra[8] = '{EFM_REG_PWR, EFM_REG_INT, EFM_REG_FRAC, EFM_REG_MCFG,
		EFM_REG_EXACT, EFM_REG_SEED, EFM_REG_PTR, 5'h1f};
	logic [23:0] rv[8] = '{EFM_RST_PWR, EFM_RST_INT, EFM_RST_FRAC, EFM_RST_MCFG,
		EFM_RST_EXACT, EFM_RST_SEED, EFM_CHIP_ID, 24'h000000};

	always #10 ref_clk_i = ~ref_clk_i;

	efm_host_model efm_host_model_i (.ref_clk_i(ref_clk_i), .reg_wr_o(wr), .reg_addr_o(addr),
		.reg_wdata_o(wdata));
	efm_ctrl #(.POR_CYCLES(8)) efm_ctrl_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_wr_i(wr),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_ready_o(ready),
		.chip_enable_pin_i(chip_enable_pin), .detector_tick_i(tick), .power_down_o(pd),
		.clocks_en_o(clk_en), .block_on_o(bon), .int_ratio_o(int_r), .frac_word_o(frac),
		.exact_ratio_o(exact), .div_ratio_o(div), .phase_o(phase), .mod_active_o(mact),
		.exact_mode_o(emode), .retune_o(retune));

	// ---------------------------------------------------------------
	// Watcher: values seen here settled on the previous edge
	// ---------------------------------------------------------------
	always @(posedge ref_clk_i) begin
		if (q.size() > 0) begin
			e = q.pop_front();
			case (e.id)
				4'h0: got = rdata;
				4'h1: got = {23'h0, pd};
				4'h2: got = {18'h0, bon};
				4'h3: got = {23'h0, clk_en};
				4'h4: got = phase;
				4'h5: got = int_r;
				4'h6: got = frac;
				4'h8: got = div;
				4'h9: got = {22'h0, mact, emode};
				default: got = exact;
			endcase
			`CHK(e.id, e.v, got)
		end
	end

	task exp(input logic [3:0] id, input logic [23:0] v);
		q.push_back('{id, v});
		@(negedge ref_clk_i);
	endtask

	// Pointer write is also a soft reset
	task rd(input logic [4:0] a, input logic [23:0] v);
		efm_host_model_i.wr(EFM_REG_PTR, {19'h0, a});
		@(negedge ref_clk_i);
		exp(4'h0, v);
	endtask

	task stop_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (8) @(negedge ref_clk_i);
		rst_i = 1'b0;
		efm_host_model_i.wr(EFM_REG_FRAC, 24'h00abcd);
		for (i = 0; i < 100 && ready !== 1'b1; i++) @(negedge ref_clk_i);
		if (ready !== 1'b1) begin
			n_mismatch++;
			stop_test();
		end
		exp(4'h6, EFM_RST_FRAC);
		seed = 24'($random(sd)) | 24'h000003;
		efm_host_model_i.tune(seed);
		exp(4'h6, 24'h938000);
		exp(4'h4, seed);
		exp(4'h5, 24'h00002d);
		exp(4'h7, 24'h000c00);
		exp(4'h9, 24'h000003);
		tick = 1'b1;
		repeat (3) @(negedge ref_clk_i);
		tick = 1'b0;
		exp(4'h4, seed + 24'h938000 * 24'h000003);
		exp(4'h8, 24'h00002d + 24'(({1'b0, seed + 24'h938000 * 24'h000002} + 25'h0938000) >> 24));
		efm_host_model_i.wr(EFM_REG_FRAC, 24'h93eaab);
		exp(4'h6, 24'h93eaab);
		exp(4'h4, seed);
		exp(4'h5, 24'h00002d);
		exp(4'h7, 24'h000c00);
		chip_enable_pin = 1'b0;
		tick = 1'b1;
		repeat (3) @(negedge ref_clk_i);
		tick = 1'b0;
		exp(4'h4, seed);
		exp(4'h1, 24'h000001);
		exp(4'h2, 24'h000000);
		exp(4'h3, 24'h000000);
		for (i = 0; i < 6; i++) begin
			efm_host_model_i.wr(EFM_REG_PWR, 24'h000001 | (24'h000004 << i));
			exp(4'h2, 24'h000001 << i);
		end
		r = 24'($random(sd));
		efm_host_model_i.wr(EFM_REG_PWR, {16'h0, r[5:0], 2'b01});
		exp(4'h2, {18'h0, r[5:0]});
		efm_host_model_i.wr(EFM_REG_PWR, 24'h000000);
		exp(4'h1, 24'h000000);
		exp(4'h3, 24'h000001);
		efm_host_model_i.wr(EFM_REG_PWR, 24'h000002);
		exp(4'h1, 24'h000001);
		// Reads taken while the pin still holds the part powered down
		for (i = 0; i < 8; i++) rd(ra[i], rv[i]);
		chip_enable_pin = 1'b1;
		exp(4'h9, 24'h000000);
		// Nonzero seed, but exact mode is off after the soft reset
		efm_host_model_i.wr(EFM_REG_SEED, seed);
		efm_host_model_i.wr(EFM_REG_FRAC, 24'h123456);
		@(negedge ref_clk_i);
		exp(4'h4, 24'h000000);
		stop_test();
	end
endmodule // efm_ctrl_tb
